// [hdl/rtff_consts.vh]
// Constants for the reserved frame type filter
`ifndef RTFF_CONSTS_VH
`define RTFF_CONSTS_VH
`define RTFF_ADDR_W          6
`define RTFF_ADDR_XCTRL      6'h17
`define RTFF_ADDR_SEED1      6'h2e
`define RTFF_XCTRL_RESET     8'h00
`define RTFF_SEED1_RESET     8'h00
`define RTFF_RDATA_NONE      8'h00
`define RTFF_BIT_ACCEPT      4
`define RTFF_BIT_FILTER      5
`define RTFF_BIT_ACK_SUPP    4
`define RTFF_FCF_TYPE_LSB    0
`define RTFF_FCF_TYPE_MSB    2
`define RTFF_FCF_ACK_REQ     5
`define RTFF_TYPE_DATA       3'h1
`define RTFF_TYPE_RES_MIN    3'h4
`endif

// [hdl/rtff_sync.v]
// Two-stage synchroniser for one pin level
`timescale 1ns/1ps
module rtff_sync
(
  // Clock and reset
  input  wire clk_sys_in,
  input  wire rst_b_in,
  // Level
  input  wire async_in,
  output reg  sync_out
);
  reg stage1;

  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // rtff_sync

// [hdl/rtff_filter.v]
// Reserved frame type filter for the auto-acknowledge receive path
// Function
// R01: Accept bit (offset 0x17 bit 4) set lets reserved-type frames through instead of rejecting.
// R02: Filter bit (offset 0x17 bit 5) sends accepted reserved frames through the data address filter.
// R03: Accept set and filter clear: each uncorrupted reserved frame raises frame-end.
// R04: Accept set and filter clear: no address filtering is applied to reserved frames.
// R05: Accept set and filter clear: no address-match event and no acknowledgement is sent.
// R06: Accept and filter set: reserved frames use the data frame address rules.
// R07: Filtered option: address match on a reserved frame raises address-match.
// R08: Filtered option: frame-end only when address matched and the frame is uncorrupted.
// R09: Filtered option: acknowledge only when ack request is set and frame-end was raised.
// R10: Accept bit clear: reserved frames are discarded with no events.
// R11: Ack suppress bit (offset 0x2e bit 4) blocks every automatic acknowledgement.
// R12: Frame type codes four to seven in the frame control field are reserved.
`timescale 1ns/1ps
`include "rtff_consts.vh"
module rtff_filter
(
  // Clock and reset
  input  wire                     clk_sys_in,
  input  wire                     rst_b_in,
  // Register port
  input  wire                     reg_wr_in,
  input  wire [`RTFF_ADDR_W-1:0]  reg_addr_in,
  input  wire [7:0]               reg_wdata_in,
  output reg  [7:0]               reg_rdata_out,
  // Receive mode select pin
  input  wire                     auto_ack_receive_mode_in,
  // Received frame from demodulator
  input  wire                     fcf_valid_in,
  input  wire [7:0]               fcf_in,
  input  wire                     addr_match_in,
  input  wire                     frame_end_in,
  input  wire                     fcs_ok_in,
  // Events and acknowledgement
  output reg                      addr_match_indication_out,
  output reg                      frame_complete_event_out,
  output reg                      ack_request_out,
  output reg                      frame_discard_out
);
  // ----------------------------------------------------------------
  // Registers and pin sync
  // ----------------------------------------------------------------
  reg  [7:0] xctrl;
  reg  [7:0] seed1;
  wire       mode_sync;
  wire       sel_xctrl;
  wire       sel_seed1;

  // Address compare, shared by the write and the read path
  function addr_is;
    input [`RTFF_ADDR_W-1:0] addr;
    input [`RTFF_ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // One select per mapped register
  assign sel_xctrl = addr_is(reg_addr_in, `RTFF_ADDR_XCTRL);
  assign sel_seed1 = addr_is(reg_addr_in, `RTFF_ADDR_SEED1);

  // Mode pin is asynchronous to this clock
  rtff_sync u_mode_sync
  (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .async_in   (auto_ack_receive_mode_in),
    .sync_out   (mode_sync)
  );

  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      xctrl <= `RTFF_XCTRL_RESET;
      seed1 <= `RTFF_SEED1_RESET;
    end
    else if (reg_wr_in)
    begin
      // R01: accept and filter bits
      if (sel_xctrl)
        xctrl <= reg_wdata_in;
      // R11: ack suppress bit
      if (sel_seed1)
        seed1 <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero so software can probe the map
  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= `RTFF_RDATA_NONE;
    else if (sel_xctrl)
      reg_rdata_out <= xctrl;
    else if (sel_seed1)
      reg_rdata_out <= seed1;
    else
      reg_rdata_out <= `RTFF_RDATA_NONE;
  end

  // ----------------------------------------------------------------
  // Frame classification
  // ----------------------------------------------------------------
  function is_reserved;
    input [2:0] ftype;
    begin
      is_reserved = (ftype >= `RTFF_TYPE_RES_MIN);
    end
  endfunction

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RECV = 3'h2;
  localparam [2:0] ST_DROP = 3'h4;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        ack_req;
  reg        matched;
  wire [2:0] ftype    = fcf_in[`RTFF_FCF_TYPE_MSB:`RTFF_FCF_TYPE_LSB];
  wire       accept   = xctrl[`RTFF_BIT_ACCEPT];
  wire       filt     = xctrl[`RTFF_BIT_FILTER];
  wire       ack_supp = seed1[`RTFF_BIT_ACK_SUPP];

  // Only reserved types are handled here; other types leave quietly
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        // Frames that start while the mode is off are never taken
        // R12: reserved type decode
        if (fcf_valid_in && mode_sync && is_reserved(ftype))
        begin
          // R10: discard when not accepted
          if (!accept)
            next_state = ST_DROP;
          // R01: accepted reserved frame
          else
            next_state = ST_RECV;
        end
      end
      ST_RECV:
        if (frame_end_in)
          next_state = ST_IDLE;
      ST_DROP:
        if (frame_end_in)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  // The header octet is only valid for one cycle, so its ack bit is kept
  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      state   <= ST_IDLE;
      ack_req <= 1'b0;
      matched <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_RECV)
      begin
        // R09: keep ack request
        ack_req <= fcf_in[`RTFF_FCF_ACK_REQ];
        matched <= 1'b0;
      end
      // R06: data filter match
      else if (state == ST_RECV && addr_match_in)
        matched <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // Filter bit is sampled live; software must not change it mid-frame
  wire end_ok   = (state == ST_RECV) && frame_end_in && fcs_ok_in;
  // Match counted once per frame, so a held match level gives one event
  wire hit_now  = (state == ST_RECV) && addr_match_in && !matched;
  wire hit_seen = matched || addr_match_in;

  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      addr_match_indication_out <= 1'b0;
      frame_complete_event_out  <= 1'b0;
      ack_request_out           <= 1'b0;
      frame_discard_out         <= 1'b0;
    end
    else
    begin
      // R02: filter bit picks the path
      // R06: data address rules drive match
      // R07: match event in filtered option
      // R05: no match event when unfiltered
      addr_match_indication_out <= hit_now && filt;
      // R03: unfiltered frame-end on good fcs
      // R04: address ignored when unfiltered
      // R08: filtered frame-end needs match
      frame_complete_event_out  <= end_ok && (!filt || hit_seen);
      // R09: ack needs request and frame-end
      // R05: unfiltered never acknowledges
      // R11: suppress overrides acknowledgement
      ack_request_out           <= end_ok && filt && hit_seen && ack_req && !ack_supp;
      // R10: discarded frame, no events
      frame_discard_out         <= (state == ST_DROP) && frame_end_in;
    end
  end
endmodule // rtff_filter

// [tb/rtff_monitor.sv]
// Checker for the reserved frame type filter
`timescale 1ns/1ps
module rtff_monitor
(
  // Inputs seen
  input wire       clk_sys_in,
  input wire       rst_b_in,
  input wire       auto_ack_receive_mode_in,
  input wire       reg_wr_in,
  input wire [5:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       fcf_valid_in,
  input wire [7:0] fcf_in,
  input wire       addr_match_in,
  input wire       frame_end_in,
  input wire       fcs_ok_in,
  // Outputs seen
  input wire       addr_match_indication_out,
  input wire       frame_complete_event_out,
  input wire       ack_request_out,
  input wire       frame_discard_out
);
  // Shadow of config and frame state, updated only from the pins
  reg acc, flt, sup, res, akq, hit, md1, md2;
  always @(posedge clk_sys_in)
    if (!rst_b_in)
      {acc, flt, sup, res, akq, hit, md1, md2} <= 8'h00;
    else
    begin
      {md2, md1} <= {md1, auto_ack_receive_mode_in};
      if (reg_wr_in && reg_addr_in == 6'h17)
        {flt, acc} <= reg_wdata_in[5:4];
      if (reg_wr_in && reg_addr_in == 6'h2e)
        sup <= reg_wdata_in[4];
      if (fcf_valid_in && !res && md2)
        {res, akq, hit} <= {fcf_in[2], fcf_in[5], 1'b0};
      else if (frame_end_in)
        res <= 1'b0;
      if (addr_match_in && res)
        hit <= 1'b1;
    end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence good_end_s;
    res && frame_end_in && fcs_ok_in;
  endsequence
  match_event_a: assert property (addr_match_in && res && acc && flt && !hit
    |=> addr_match_indication_out) else $error("match event missing");
  match_cause_a: assert property (addr_match_indication_out
    |-> $past(addr_match_in && res && acc && flt)) else $error("stray match event");
  open_end_a: assert property ((acc && !flt) ##0 good_end_s
    |=> frame_complete_event_out) else $error("frame end missing");
  filt_end_a: assert property ((acc && flt && hit) ##0 good_end_s
    |=> frame_complete_event_out) else $error("filtered end missing");
  end_cause_a: assert property (frame_complete_event_out
    |-> $past(res && frame_end_in && fcs_ok_in && acc && (!flt || hit))) else $error("stray end");
  ack_make_a: assert property ((acc && flt && hit && akq && !sup) ##0 good_end_s
    |=> ack_request_out) else $error("ack missing");
  ack_cause_a: assert property (ack_request_out |-> $past(flt && hit && akq && !sup))
    else $error("stray ack");
  drop_event_a: assert property (!acc && frame_end_in && res
    |=> frame_discard_out && !frame_complete_event_out) else $error("discard wrong");
endmodule // rtff_monitor
bind rtff_filter rtff_monitor mon (.*);

// [tb/rtff_radio.sv]
// Frame source standing in for the demodulator
`timescale 1ns/1ps
module rtff_radio
(
  // Clock
  input  wire       clk_sys_in,
  // Frame lines
  output reg        fcf_valid_out,
  output reg  [7:0] fcf_out,
  output reg        addr_match_out,
  output reg        frame_end_out,
  output reg        fcs_ok_out
);
  // Idle header lines carry junk so a stale value never passes; match stays low
  initial {fcf_valid_out, fcf_out, addr_match_out, frame_end_out, fcs_ok_out} = 12'h0a1;
  task send(input [7:0] f, input m, input ok, input [1:0] gap);
    begin
      @(negedge clk_sys_in) {fcf_valid_out, fcf_out} <= {1'b1, f};
      @(negedge clk_sys_in) {fcf_valid_out, fcf_out} <= {1'b0, ~f};
      @(negedge clk_sys_in) addr_match_out <= m;
      @(negedge clk_sys_in) addr_match_out <= 1'b0;
      repeat (gap) @(negedge clk_sys_in);
      {frame_end_out, fcs_ok_out} <= {1'b1, ok};
      @(negedge clk_sys_in) {frame_end_out, fcs_ok_out} <= {1'b0, ~ok};
      repeat (3) @(negedge clk_sys_in);
    end
  endtask
endmodule // rtff_radio

// [tb/rtff_filter_tb.sv]
// Bench for the reserved frame type filter
`timescale 1ns/1ps
module rtff_filter_tb;
  reg        clk_sys_in = 1'b0;
  reg        rst_b_in = 1'b0;
  reg        wr = 1'b0;
  reg  [5:0] ad = 6'h00;
  reg  [7:0] wd = 8'h00;
  reg        mode = 1'b1;
  reg  [3:0] seen = 4'h0;
  reg  [3:0] e;
  reg  [7:0] f;
  wire [7:0] rd_d, fcf;
  wire       fv, am, fe, ok, o_am, o_fe, o_ak, o_ds;
  integer    error_cnt = 0, compares = 0, cyc = 0, i;
  rtff_radio rad (.clk_sys_in(clk_sys_in), .fcf_valid_out(fv), .fcf_out(fcf),
    .addr_match_out(am), .frame_end_out(fe), .fcs_ok_out(ok));
  // Mode pin is driven so that frames outside the auto-ack mode are tried too
  rtff_filter uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_wr_in(wr),
    .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rd_d),
    .auto_ack_receive_mode_in(mode), .fcf_valid_in(fv), .fcf_in(fcf), .addr_match_in(am),
    .frame_end_in(fe), .fcs_ok_in(ok), .addr_match_indication_out(o_am),
    .frame_complete_event_out(o_fe), .ack_request_out(o_ak), .frame_discard_out(o_ds));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    seen <= seen | {o_am, o_fe, o_ak, o_ds};
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task chk(input [47:0] nm, input [7:0] ex, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== ex)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", nm, ex, g);
      end
    end
  endtask
  task chk_ev(input [47:0] nm, input [3:0] ex);
    begin
      compares = compares + 1;
      if (seen !== ex)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", nm, ex, seen);
      end
    end
  endtask
  task wreg(input [5:0] a, input [7:0] d);
    begin
      @(negedge clk_sys_in) {wr, ad, wd} <= {1'b1, a, d};
      @(negedge clk_sys_in) wr <= 1'b0;
    end
  endtask
  task rreg(input [5:0] a, input [7:0] ex);
    begin
      @(negedge clk_sys_in) ad <= a;
      repeat (2) @(negedge clk_sys_in);
      chk("reg", ex, rd_d);
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys_in);
    rst_b_in <= 1'b1;
    rreg(6'h17, 8'h00);
    rreg(6'h2e, 8'h00);
    wreg(6'h17, 8'h30);
    rreg(6'h17, 8'h30);
    rreg(6'h3f, 8'h00);
    $display("register test done");
    // Sweep suppress, accept, filter, type, match and checksum together
    for (i = 0; i < 128; i = i + 1)
    begin
      if (i[3:0] == 0)
        wreg(6'h17, {2'b00, i[5:4], 4'h0});
      if (i[5:0] == 0)
        wreg(6'h2e, {3'b000, i[6], 4'h0});
      f = (i[3:2] == 3) ? 8'h07 : (i[3:2] == 2) ? 8'h21 : {6'h09, i[3:2]};
      e[3] = f[2] & i[4] & i[5] & i[1];
      e[2] = f[2] & i[4] & i[0] & (~i[5] | i[1]);
      e[1] = e[2] & i[5] & f[5] & ~i[6];
      e[0] = f[2] & ~i[4];
      seen = 4'h0;
      rad.send(f, i[1], i[0], i[1:0]);
      chk_ev("events", e);
    end
    $display("frame test done");
    // Frames count only in the auto-ack receive mode; config is 0x30, suppress on
    @(negedge clk_sys_in) mode <= 1'b0;
    repeat (3) @(negedge clk_sys_in);
    seen = 4'h0;
    rad.send(8'h24, 1'b1, 1'b1, 2'd1);
    chk_ev("nomode", 4'h0);
    @(negedge clk_sys_in) mode <= 1'b1;
    repeat (3) @(negedge clk_sys_in);
    seen = 4'h0;
    rad.send(8'h24, 1'b1, 1'b1, 2'd1);
    chk_ev("mode", 4'hc);
    $display("mode test done");
    wrap_up;
  end
endmodule // rtff_filter_tb
